// >>> rtl/wcab_top.sv
// Top of the window comparator alert buffer: registers, alert decision, sample buffer, interrupt.
// Assumes conversion results arrive as one-cycle strobes synchronous to clk_sys.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
module wcab_top
   import wcab_pkg::*;
#(
   parameter int DEPTH = BUF_DEPTH
)(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // Conversion results
   input  wire logic              conv_valid,
   input  wire logic              conv_chan,
   input  wire logic [RES_W-1:0]  conv_data,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Outputs to host
   output logic                   alert,
   output logic                   irq
);
   typedef struct packed {
      logic [NCHAN-1:0]  low_flag;
      logic [NCHAN-1:0]  high_flag;
      logic [3:0]        trig_chan;
      logic [3:0]        ev_count;
      logic              post_mode;
      logic              armed;
      wcab_state_t       state;
      logic [3:0]        wptr;
      logic [4:0]        fill;
      logic              smp_valid;
      logic              smp_chan;
      logic [RES_W-1:0]  smp_data;
      logic              lsmp_v;
      logic [RES_W-1:0]  lsmp_data;
      logic              alert;
      logic [1:0]        irq_stat;
      logic [1:0]        irq_mask;
      logic              irq;
      logic [DATA_W-1:0] rdata;
   } wcab_top_state_t;

   wcab_top_state_t  st_r;
   wcab_top_state_t  st_nxt;
   wcab_chan_cfg_t   cfg_r   [NCHAN];
   logic [RES_W-1:0] buf_mem [DEPTH];
   logic [1:0]       rst_sync_r;
   logic             rst_n;

   // Reset released through two flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   logic [NCHAN-1:0] low_ev;
   logic [NCHAN-1:0] high_ev;

   genvar g;
   generate
      for (g = 0; g < NCHAN; g++) begin : g_chan
         wcab_cmp_if link ();
         assign link.cfg       = cfg_r[g];
         assign link.ev_count  = st_r.ev_count;
         // Each channel only sees its own results
         assign link.smp_valid = st_r.smp_valid && (st_r.smp_chan == 1'(g));
         assign link.smp_data  = st_r.smp_data;
         assign low_ev[g]      = link.low_event;
         assign high_ev[g]     = link.high_event;
         wcab_chan_cmp u_cmp (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .link    (link)
         );
      end
   endgenerate

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      return a == b;
   endfunction

   // Threshold and hysteresis registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NCHAN; i++) begin
            cfg_r[i].low_thr  <= LTH_RESET;
            cfg_r[i].high_thr <= HTH_RESET;
            cfg_r[i].hyst     <= HYS_RESET;
         end
      end else if (reg_wr) begin
         if (hit(reg_addr, ADDR_LTH_CH0)) cfg_r[0].low_thr  <= reg_wdata[RES_W-1:0];
         if (hit(reg_addr, ADDR_HTH_CH0)) cfg_r[0].high_thr <= reg_wdata[RES_W-1:0];
         if (hit(reg_addr, ADDR_HYS_CH0)) cfg_r[0].hyst     <= reg_wdata[5:0];
         if (hit(reg_addr, ADDR_LTH_CH1)) cfg_r[1].low_thr  <= reg_wdata[RES_W-1:0];
         if (hit(reg_addr, ADDR_HTH_CH1)) cfg_r[1].high_thr <= reg_wdata[RES_W-1:0];
         if (hit(reg_addr, ADDR_CHAN1_HYSTERESIS)) cfg_r[1].hyst     <= reg_wdata[5:0];
      end
   end

   logic        fire;
   logic        fire_chan;
   logic        buf_we;
   logic [3:0]  buf_addr;

   always_comb begin
      st_nxt = st_r;
      buf_we = 1'b0;
      buf_addr = st_r.wptr;
      // Register the sample by one cycle before it reaches the channel comparators
      st_nxt.smp_valid = conv_valid;
      st_nxt.smp_chan  = conv_chan;
      st_nxt.smp_data  = conv_data;
      // Second stage lines the sample up with the event pulse it caused
      st_nxt.lsmp_v    = st_r.smp_valid;
      st_nxt.lsmp_data = st_r.smp_data;

      // Channel 0 wins a tie, though ties cannot happen with one sample per cycle
      fire      = |(low_ev | high_ev);
      fire_chan = !(low_ev[0] | high_ev[0]);

      // Flags latch; write-one clears, but a new event in the same cycle wins
      if (reg_wr && hit(reg_addr, ADDR_LOW_FLAGS))
         st_nxt.low_flag = st_r.low_flag & ~reg_wdata[NCHAN-1:0];
      if (reg_wr && hit(reg_addr, ADDR_HIGH_FLAGS))
         st_nxt.high_flag = st_r.high_flag & ~reg_wdata[NCHAN-1:0];
      st_nxt.low_flag  = st_nxt.low_flag | low_ev;
      st_nxt.high_flag = st_nxt.high_flag | high_ev;

      if (reg_wr && hit(reg_addr, ADDR_EVENT_COUNT))
         st_nxt.ev_count = reg_wdata[EVCNT_LSB +: 4];

      if (reg_wr && hit(reg_addr, ADDR_IRQ_MASK))
         st_nxt.irq_mask = reg_wdata[1:0];

      // Status read clears first, so an event in the same cycle wins
      if (reg_rd && hit(reg_addr, ADDR_IRQ_STATUS))
         st_nxt.irq_stat = 2'b00;

      // The alerting sample sits in lsmp_* while its event pulse is out
      case (st_r.state)
         WCAB_IDLE: begin
            st_nxt.alert = 1'b0;
         end
         WCAB_WATCH: begin
            if (!st_r.post_mode && st_r.smp_valid) begin
               // No write here; the delayed copy of the sample that produced the pulse is written below
               buf_we = 1'b0;
            end
            if (fire) begin
               st_nxt.alert     = 1'b1;
               st_nxt.trig_chan = {3'b000, fire_chan};
               st_nxt.irq_stat[IRQ_ALERT_BIT] = 1'b1;
               if (st_r.post_mode) begin
                  st_nxt.state = WCAB_CAPTURE;
                  st_nxt.fill  = 5'h00;
               end else begin
                  st_nxt.state = WCAB_HOLD;
               end
            end
         end
         WCAB_CAPTURE: begin
            if (st_r.fill == 5'(DEPTH)) begin
               st_nxt.state = WCAB_HOLD;
               st_nxt.irq_stat[IRQ_FULL_BIT] = 1'b1;
            end
         end
         WCAB_HOLD: begin
         end
         default: st_nxt.state = WCAB_IDLE;
      endcase

      // Buffer write uses the last-seen sample word held in lsmp
      if (st_r.lsmp_v && ((st_r.state == WCAB_WATCH && !st_r.post_mode) ||
                     (st_r.state == WCAB_CAPTURE && st_r.fill < 5'(DEPTH)) ||
                     (st_r.state == WCAB_WATCH && st_r.post_mode && fire))) begin
         buf_we       = 1'b1;
         st_nxt.wptr  = st_r.wptr + 4'h1;
         st_nxt.fill  = ((st_r.state == WCAB_WATCH) ? 5'h00 : st_r.fill) + 5'h01;
      end
      if (st_r.state == WCAB_WATCH && !st_r.post_mode && !fire && st_r.lsmp_v)
         st_nxt.fill = (st_r.fill == 5'(DEPTH)) ? st_r.fill : st_r.fill + 5'h01;
      if (st_r.state == WCAB_WATCH && !st_r.post_mode && fire)
         st_nxt.irq_stat[IRQ_FULL_BIT] = 1'b1;

      // Writing arm restarts capture and clears the trigger record
      if (reg_wr && hit(reg_addr, ADDR_CTRL)) begin
         st_nxt.post_mode = reg_wdata[CTRL_POST_BIT];
         st_nxt.armed     = reg_wdata[CTRL_ARM_BIT];
         st_nxt.state     = reg_wdata[CTRL_ARM_BIT] ? WCAB_WATCH : WCAB_IDLE;
         st_nxt.alert     = 1'b0;
         st_nxt.trig_chan = 4'h0;
         st_nxt.wptr      = 4'h0;
         st_nxt.fill      = 5'h00;
      end

      // Read data, one cycle later; status read clears sticky bits unless an event sets them now
      st_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_TRIG_CHAN:   st_nxt.rdata[TRIG_LSB +: 4] = st_r.trig_chan;
            ADDR_LOW_FLAGS:   st_nxt.rdata[NCHAN-1:0] = st_r.low_flag;
            ADDR_HIGH_FLAGS:  st_nxt.rdata[NCHAN-1:0] = st_r.high_flag;
            ADDR_EVENT_COUNT: st_nxt.rdata[EVCNT_LSB +: 4] = st_r.ev_count;
            ADDR_CTRL:        st_nxt.rdata[1:0] = {st_r.armed, st_r.post_mode};
            ADDR_IRQ_STATUS: begin
               st_nxt.rdata[1:0] = st_r.irq_stat;
            end
            ADDR_IRQ_MASK:    st_nxt.rdata[1:0] = st_r.irq_mask;
            ADDR_BUF_STATUS:  st_nxt.rdata[9:0] = {st_r.state, st_r.fill[4:0], 3'b000} >> 3;
            ADDR_LTH_CH0:     st_nxt.rdata[RES_W-1:0] = cfg_r[0].low_thr;
            ADDR_HTH_CH0:     st_nxt.rdata[RES_W-1:0] = cfg_r[0].high_thr;
            ADDR_HYS_CH0:     st_nxt.rdata[5:0] = cfg_r[0].hyst;
            ADDR_LTH_CH1:     st_nxt.rdata[RES_W-1:0] = cfg_r[1].low_thr;
            ADDR_HTH_CH1:     st_nxt.rdata[RES_W-1:0] = cfg_r[1].high_thr;
            ADDR_CHAN1_HYSTERESIS:     st_nxt.rdata[5:0] = cfg_r[1].hyst;
            default: begin
               // Buffer window: entry 0 is the oldest sample kept
               if (reg_addr[7:4] == ADDR_BUF_BASE[7:4])
                  st_nxt.rdata[RES_W-1:0] = buf_mem[4'(st_r.wptr + reg_addr[3:0])];
            end
         endcase
      end

      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   always_ff @(posedge clk_sys) begin
      if (buf_we)
         buf_mem[buf_addr] <= st_r.lsmp_data;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign reg_rdata = st_r.rdata;
   assign alert     = st_r.alert;
   assign irq       = st_r.irq;
endmodule // wcab_top

// >>> rtl/wcab_pkg.sv
// Constants and types for the window comparator alert buffer.
// Assumes one 50 MHz clock and a plain register port with single-cycle strobes.
package wcab_pkg;
   localparam int RES_W   = 12;
   localparam int NCHAN   = 2;
   localparam int BUF_DEPTH = 16;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;

   localparam logic [RES_W-1:0] FULL_SCALE = 12'hFFF;
   localparam logic [RES_W-1:0] ZERO_SCALE = 12'h000;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_TRIG_CHAN   = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_LOW_FLAGS   = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_HIGH_FLAGS  = 8'h0E;
   localparam logic [ADDR_W-1:0] ADDR_EVENT_COUNT = 8'h36;
   localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h50;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h51;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h52;
   localparam logic [ADDR_W-1:0] ADDR_BUF_STATUS  = 8'h53;
   localparam logic [ADDR_W-1:0] ADDR_LTH_CH0     = 8'h60;
   localparam logic [ADDR_W-1:0] ADDR_HTH_CH0     = 8'h61;
   localparam logic [ADDR_W-1:0] ADDR_HYS_CH0     = 8'h62;
   localparam logic [ADDR_W-1:0] ADDR_LTH_CH1     = 8'h64;
   localparam logic [ADDR_W-1:0] ADDR_HTH_CH1     = 8'h65;
   localparam logic [ADDR_W-1:0] ADDR_CHAN1_HYSTERESIS     = 8'h66;
   localparam logic [ADDR_W-1:0] ADDR_BUF_BASE    = 8'h80;

   // Field positions
   localparam int EVCNT_LSB = 4;
   localparam int TRIG_LSB  = 4;
   localparam int CTRL_POST_BIT = 0;
   localparam int CTRL_ARM_BIT  = 1;
   localparam int IRQ_ALERT_BIT = 0;
   localparam int IRQ_FULL_BIT  = 1;

   // Reset values
   localparam logic [RES_W-1:0] LTH_RESET  = 12'h000;
   localparam logic [RES_W-1:0] HTH_RESET  = 12'hFFF;
   localparam logic [5:0]       HYS_RESET  = 6'h00;
   localparam logic [3:0]       EVCNT_RESET = 4'h0;

   typedef enum logic [1:0] {
      WCAB_IDLE    = 2'b00,
      WCAB_WATCH   = 2'b01,
      WCAB_CAPTURE = 2'b11,
      WCAB_HOLD    = 2'b10
   } wcab_state_t;

   typedef struct packed {
      logic [RES_W-1:0] low_thr;
      logic [RES_W-1:0] high_thr;
      logic [5:0]       hyst;
   } wcab_chan_cfg_t;
endpackage : wcab_pkg

// >>> rtl/wcab_cmp_if.sv
// Carries one channel's comparator settings, sample strobe and result between modules.
// Assumes the owner of the thresholds drives cfg and the sample strobe.
interface wcab_cmp_if;
   import wcab_pkg::*;
   wcab_chan_cfg_t   cfg;
   logic [3:0]       ev_count;
   logic             smp_valid;
   logic [RES_W-1:0] smp_data;
   logic             low_event;
   logic             high_event;

   modport ctrl (output cfg, output ev_count, output smp_valid, output smp_data,
                 input low_event, input high_event);
   modport cmp  (input cfg, input ev_count, input smp_valid, input smp_data,
                 output low_event, output high_event);
endinterface : wcab_cmp_if

// >>> rtl/wcab_chan_cmp.sv
// One channel's window comparator with hysteresis and run counters.
// Assumes settings are stable around a sample strobe; events are one-cycle pulses.
module wcab_chan_cmp
   import wcab_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Channel link
   wcab_cmp_if.cmp  link
);
   typedef struct packed {
      logic       low_arm;
      logic       high_arm;
      logic [4:0] low_run;
      logic [4:0] high_run;
      logic       low_ev;
      logic       high_ev;
   } wcab_cmp_state_t;

   wcab_cmp_state_t st_r;
   wcab_cmp_state_t st_nxt;

   logic [RES_W:0] low_rel;
   logic [RES_W:0] high_rel;
   logic           low_hit;
   logic           high_hit;
   logic [4:0]     need;

   // Hysteresis widens the drop-out side: once set, a comparator stays set until the result clears by hyst
   always_comb begin
      low_rel  = {1'b0, link.cfg.low_thr} + (st_r.low_arm ? {7'h00, link.cfg.hyst} : 13'h0000);
      high_rel = {1'b0, link.cfg.high_thr} - (st_r.high_arm ? {7'h00, link.cfg.hyst} : 13'h0000);
      if (high_rel[RES_W])
         high_rel = 13'h0000;
      // Plain compares give full-scale and zero settings their one-code behaviour
      low_hit  = ({1'b0, link.smp_data} <= low_rel);
      high_hit = ({1'b0, link.smp_data} >= high_rel);
      need     = {1'b0, link.ev_count} + 5'h01;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.low_ev  = 1'b0;
      st_nxt.high_ev = 1'b0;
      if (link.smp_valid) begin
         st_nxt.low_arm  = low_hit;
         st_nxt.high_arm = high_hit;
         if (!low_hit)
            st_nxt.low_run = 5'h00;
         else if (st_r.low_run < need) begin
            st_nxt.low_run = st_r.low_run + 5'h01;
            st_nxt.low_ev  = (st_r.low_run + 5'h01 == need);
         end
         if (!high_hit)
            st_nxt.high_run = 5'h00;
         else if (st_r.high_run < need) begin
            st_nxt.high_run = st_r.high_run + 5'h01;
            st_nxt.high_ev  = (st_r.high_run + 5'h01 == need);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign link.low_event  = st_r.low_ev;
   assign link.high_event = st_r.high_ev;
endmodule // wcab_chan_cmp

// >>> tb/wcab_chk.sv
// Port-level assertions for the window comparator alert buffer.
// Assumes one clock domain and a master that never raises both strobes at once.
module wcab_chk
   import wcab_pkg::*;
#(
   parameter int DEPTH = BUF_DEPTH
)(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Conversions and register port
   input wire logic              conv_valid,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Host outputs
   input wire logic              alert,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_rd(logic [ADDR_W-1:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_wr(logic [ADDR_W-1:0] a);
      reg_wr && reg_addr == a;
   endsequence

   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside a read");
   AST_UNMAPPED: assert property (s_rd(8'h20) |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   AST_BUF_FMT: assert property (reg_rd && reg_addr[7:4] == 4'h8 |=> reg_rdata[15:12] == 4'h0)
      else $error("buffer entry wider than a result");
   AST_FLAG_FMT: assert property (reg_rd && (reg_addr == ADDR_LOW_FLAGS || reg_addr == ADDR_HIGH_FLAGS)
      |=> reg_rdata[15:2] == '0)
      else $error("flag register reserved bits set");
   AST_TRIG_FMT: assert property (s_rd(ADDR_TRIG_CHAN) |=> reg_rdata[15:5] == '0 && reg_rdata[3:0] == 4'h0)
      else $error("trigger channel code out of range");
   AST_EVCNT_FMT: assert property (s_rd(ADDR_EVENT_COUNT) |=> {reg_rdata[15:8], reg_rdata[3:0]} == '0)
      else $error("event count reserved bits set");
   AST_ALERT_CAUSE: assert property ($rose(alert) |-> $past(conv_valid, 3))
      else $error("alert rose without a conversion three cycles before");
   AST_ALERT_HOLD: assert property (alert && !(reg_wr && reg_addr == ADDR_CTRL) |=> alert)
      else $error("alert dropped without a control write");
   AST_CTRL_CLEAR: assert property (s_wr(ADDR_CTRL) |=> ##1 !alert)
      else $error("control write did not clear alert");
   AST_IRQ_MASK: assert property (s_wr(ADDR_IRQ_MASK) ##0 reg_wdata[1:0] == 2'h0 |-> ##2 !irq)
      else $error("interrupt high with all sources masked");
endmodule // wcab_chk

bind wcab_top wcab_chk #(.DEPTH(DEPTH)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .conv_valid(conv_valid),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .alert(alert), .irq(irq));

// >>> tb/wcab_host.sv
// Host controller model: masters the register port with single-cycle strobes.
// Assumes the bench calls its tasks just after a rising edge of clk_sys.
module wcab_host
   import wcab_pkg::*;
(
   // Clock
   input  wire logic              clk_sys,
   // Register port
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_wr,
   output logic                   reg_rd,
   input  wire logic [DATA_W-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      // Stale data would hide a slave that latches late
      reg_wdata <= ~d;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      // Read data stand only in the cycle after the strobe: take them at its closing edge
      @(posedge clk_sys);
      d = reg_rdata;
   endtask

   // Flags clear by writing one to their bits; m picks which, one or both at once
   task automatic clr(input logic [ADDR_W-1:0] a, input logic [1:0] m);
      wr(a, {14'h0, m});
   endtask
endmodule // wcab_host

// >>> tb/tb_window_comparator_alert_buffer.sv
// Self-checking bench for the window comparator alert buffer.
// Assumes the host model masters registers; conversions are driven here.
module tb_window_comparator_alert_buffer;
   timeunit 1ns;
   timeprecision 1ps;
   import wcab_pkg::*;

   logic              clk_sys = 1'h0;
   logic              reset_n;
   logic              conv_valid;
   logic              conv_chan;
   logic [RES_W-1:0]  conv_data;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              alert;
   logic              irq;
   logic [DATA_W-1:0] rdv;
   int                n_mismatch = 0;
   int                samples_checked = 0;
   int                cyc = 0;

   always #10 clk_sys = ~clk_sys;

   wcab_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   wcab_top #(.DEPTH(BUF_DEPTH)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .conv_valid(conv_valid),
      .conv_chan(conv_chan), .conv_data(conv_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert(alert), .irq(irq));

   task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      u_host.rd(a, d);
      chk(name, d, exp);
   endtask

   task automatic send(input logic ch, input logic [RES_W-1:0] q[$]);
      foreach (q[i]) begin
         conv_valid <= 1'h1;
         conv_chan <= ch;
         conv_data <= q[i];
         @(posedge clk_sys);
      end
      conv_valid <= 1'h0;
      conv_data <= ~q[q.size()-1];
      // Alert lands three edges after the last conversion
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic bufchk(input logic [RES_W-1:0] exp[$]);
      for (int k = 0; k < BUF_DEPTH; k++) begin
         rchk("buffer entry", ADDR_BUF_BASE + 8'(k), {4'h0, exp[k]});
      end
   endtask

   task automatic t_reset_vals;
      rchk("low threshold", ADDR_LTH_CH0, 16'h0000);
      rchk("high threshold", ADDR_HTH_CH0, 16'h0FFF);
      rchk("event count", ADDR_EVENT_COUNT, 16'h0000);
      u_host.wr(8'h20, 16'hFFFF);
      rchk("unmapped", 8'h20, 16'h0000);
      u_host.wr(ADDR_CHAN1_HYSTERESIS, 16'h00FF);
      rchk("hysteresis field", ADDR_CHAN1_HYSTERESIS, 16'h003F);
      u_host.wr(ADDR_CHAN1_HYSTERESIS, 16'h0000);
   endtask

   task automatic t_one_sided;
      u_host.wr(ADDR_CTRL, 16'h0002);
      send(1'h0, '{12'h001, 12'hFFE, 12'h800});
      chk("alert near ends", 16'(alert), 16'h0000);
      send(1'h0, '{12'hFFF});
      chk("alert full scale", 16'(alert), 16'h0001);
      rchk("high flags", ADDR_HIGH_FLAGS, 16'h0001);
      u_host.wr(ADDR_CTRL, 16'h0002);
      send(1'h0, '{12'h000});
      chk("alert zero", 16'(alert), 16'h0001);
      rchk("low flags", ADDR_LOW_FLAGS, 16'h0001);
      u_host.clr(ADDR_LOW_FLAGS, 2'h1);
      u_host.clr(ADDR_HIGH_FLAGS, 2'h1);
      rchk("low cleared", ADDR_LOW_FLAGS, 16'h0000);
      rchk("high cleared", ADDR_HIGH_FLAGS, 16'h0000);
   endtask

   task automatic t_pre;
      logic [RES_W-1:0] s[$];
      for (int i = 0; i < 20; i++) s.push_back(12'h200 + 12'(i));
      s = {s, 12'h100, 12'h0F0, 12'h500, 12'h0F0, 12'h0F0};
      u_host.wr(ADDR_LTH_CH0, 16'h0100);
      u_host.wr(ADDR_HTH_CH0, 16'h0E00);
      u_host.wr(ADDR_EVENT_COUNT, 16'h0020);
      u_host.wr(ADDR_IRQ_MASK, 16'h0001);
      u_host.wr(ADDR_CTRL, 16'h0002);
      rchk("event count", ADDR_EVENT_COUNT, 16'h0020);
      send(1'h0, s);
      chk("alert broken run", 16'(alert), 16'h0000);
      send(1'h0, '{12'h0A5, 12'h300, 12'h301});
      chk("alert full run", 16'(alert), 16'h0001);
      chk("irq", 16'(irq), 16'h0001);
      rchk("trigger channel", ADDR_TRIG_CHAN, 16'h0000);
      rchk("low flags", ADDR_LOW_FLAGS, 16'h0001);
      s.push_back(12'h0A5);
      bufchk(s[s.size()-16:s.size()-1]);
      u_host.rd(ADDR_IRQ_STATUS, rdv);
      chk("irq status", rdv, 16'h0003);
      repeat (2) @(posedge clk_sys);
      chk("irq after read", 16'(irq), 16'h0000);
   endtask

   task automatic t_post;
      logic [RES_W-1:0] s[$];
      for (int i = 0; i < 20; i++) s.push_back(12'h900 + 12'(i));
      u_host.wr(ADDR_HTH_CH1, 16'h0800);
      u_host.wr(ADDR_EVENT_COUNT, 16'h0010);
      u_host.wr(ADDR_IRQ_MASK, 16'h0000);
      u_host.wr(ADDR_CTRL, 16'h0003);
      send(1'h1, '{12'h900, 12'h7FF, 12'h001, 12'h800});
      send(1'h0, '{12'h400, 12'h0F0});
      chk("alert split run", 16'(alert), 16'h0000);
      send(1'h1, {12'h810, s});
      chk("alert", 16'(alert), 16'h0001);
      chk("irq masked", 16'(irq), 16'h0000);
      rchk("trigger channel", ADDR_TRIG_CHAN, 16'h0010);
      rchk("high flags", ADDR_HIGH_FLAGS, 16'h0002);
      bufchk({12'h810, s[0:14]});
      u_host.wr(ADDR_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge clk_sys);
      chk("irq unmasked", 16'(irq), 16'h0001);
      u_host.clr(ADDR_HIGH_FLAGS, 2'h2);
      rchk("high cleared", ADDR_HIGH_FLAGS, 16'h0000);
   endtask

   task automatic final_report;
      if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Whole run needs well under two thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      reset_n = 1'h0;
      conv_valid = 1'h0;
      conv_chan = 1'h0;
      conv_data = '0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      t_reset_vals();
      t_one_sided();
      t_pre();
      t_post();
      final_report();
   end
endmodule // tb_window_comparator_alert_buffer
